// ==== ldc_clk_div.v ====
// Purpose: Selects and divides the display clock source into ticks
// Assumes: Oscillator levels already pass a two-flop synchroniser
// Notes:   One mclk-wide tick per divided source period
`timescale 1ns/1ps
`default_nettype none
`include "ldc_map.vh"

module ldc_clk_div #(
	parameter SYS_DIV = `LDC_SYS_DIV
) (
	input  wire       mclk,
	input  wire       rstn,
	input  wire [1:0] clkSel,
	input  wire       secOscSync,
	input  wire       lfOscSync,
	output reg        srcTick
);

	// ************************************************************
	// Source edge detect and counters
	// ************************************************************
	reg  [12:0] sysCnt_q;
	reg  [4:0]  oscCnt_q;
	reg         oscPrev_q;
	wire        oscLevel;
	wire        oscRise;
	wire        sysWrap;

	// Upper select bit wins regardless of the lower one
	assign oscLevel = clkSel[1] ? lfOscSync : secOscSync; // RULE_06
	assign oscRise  = oscLevel & ~oscPrev_q;
	assign sysWrap  = (sysCnt_q == SYS_DIV[12:0] - 13'h0001) |
		(sysCnt_q == 13'h1FFF);

	always @(posedge mclk) begin
		if (!rstn) begin
			sysCnt_q  <= 13'h0000;
			oscCnt_q  <= 5'h00;
			oscPrev_q <= 1'b0;
			srcTick   <= 1'b0;
		end else begin
			oscPrev_q <= oscLevel;
			sysCnt_q  <= sysWrap ? 13'h0000 : sysCnt_q + 13'h0001;
			if (oscRise)
				oscCnt_q <= oscCnt_q + 5'h01;
			if (clkSel == `LDC_CS_SYSTEM)
				srcTick <= sysWrap; // RULE_04
			else if (clkSel == `LDC_CS_SECOND)
				srcTick <= oscRise & (oscCnt_q == `LDC_OSC_DIV); // RULE_05
			else
				srcTick <= oscRise & (oscCnt_q == `LDC_OSC_DIV); // RULE_06
		end
	end

endmodule
`default_nettype wire

// ==== ldc_control.v ====
// Purpose: Display driver control fields, pixel data and APB slave
// Assumes: Oscillator pins asynchronous to mclk; zero-wait APB
// Notes:   Only the low control fields are built, with all four multiplex settings
//
// Operation
// RULE_01: Blocked pixel write sets write-failed flag
// RULE_02: Flag holds until software clears it
// RULE_03: Bias enable bit drives bias pins
// RULE_04: Select 00 uses system clock divided 8192
// RULE_05: Select 01 uses secondary oscillator over 32
// RULE_06: Select 1x uses low-frequency oscillator over 32
// RULE_07: Commons 00 means static, first common only
// RULE_08: Prescaler register shows read-only write-allow bit
//
// The APB slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "ldc_map.vh"

module ldc_control #(
	parameter SYS_DIV = `LDC_SYS_DIV
) (
	input  wire        mclk,
	input  wire        rstn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output wire        pready,
	output wire        pslverr,
	output reg         irq,
	input  wire        secOscPin,
	input  wire        lfOscPin,
	output reg         biasPinEnable,
	output reg  [3:0]  commonEnable,
	output reg         staticBias,
	output reg  [31:0] pixelData,
	output reg         frameTick,
	output wire        writeAllow
);

	// ************************************************************
	// Address decode helpers
	// ************************************************************
	function isPixel;
		input [7:0] a;
		begin
			isPixel = (a >= `LDC_OFS_PIX0) && (a <= `LDC_OFS_PIX3) &&
				(a[1:0] == 2'h0);
		end
	endfunction

	function isMapped;
		input [7:0] a;
		begin
			isMapped = isPixel(a) ||
				(a == `LDC_OFS_CTRL) ||
				(a == `LDC_OFS_PRESC) ||
				(a == `LDC_OFS_INTSTAT) ||
				(a == `LDC_OFS_INTMASK);
		end
	endfunction

	// ************************************************************
	// Declarations
	// ************************************************************
	reg         biasEn_q;
	reg  [1:0]  clkSel_q;
	reg  [1:0]  muxSel_q;
	reg         write_failed_error_flag_q;
	reg         write_failed_error_flag_d;
	reg  [3:0]  presc_q;
	reg  [3:0]  prescCnt_q;
	reg  [2:0]  waBlock_q;
	reg  [7:0]  pixMem_q [0:3];
	reg  [1:0]  intStat_q;
	reg  [1:0]  intStat_d;
	reg  [1:0]  intMask_q;
	reg         secMeta_q;
	reg         secSync_q;
	reg         lfMeta_q;
	reg         lfSync_q;
	reg  [7:0]  rdWord;
	wire        srcTick;
	wire        setup;
	wire        access;
	wire        wrAccess;
	wire        pixWrite;
	wire        pixFail;
	wire        ctrlWrite;
	wire        statWrite;
	wire [1:0]  pixIdx;
	wire        prescWrap;
	integer     i;

	// ************************************************************
	// Bus handshake
	// ************************************************************
	// Every access completes in one access cycle, so pready is tied high
	assign setup     = psel & ~penable;
	assign access    = psel & penable;
	assign pready    = 1'b1;
	assign pslverr   = access & ~isMapped(paddr);
	assign wrAccess  = access & pwrite & isMapped(paddr);
	assign pixWrite  = wrAccess & isPixel(paddr);
	assign pixIdx    = paddr[3:2];
	assign ctrlWrite = wrAccess & (paddr == `LDC_OFS_CTRL);
	assign statWrite = wrAccess & (paddr == `LDC_OFS_INTSTAT);

	// ************************************************************
	// Oscillator synchronisers
	// ************************************************************
	always @(posedge mclk) begin
		if (!rstn) begin
			secMeta_q <= 1'b0;
			secSync_q <= 1'b0;
			lfMeta_q  <= 1'b0;
			lfSync_q  <= 1'b0;
		end else begin
			secMeta_q <= secOscPin;
			secSync_q <= secMeta_q;
			lfMeta_q  <= lfOscPin;
			lfSync_q  <= lfMeta_q;
		end
	end

	// ************************************************************
	// Clock source selection
	// ************************************************************
	ldc_clk_div #(
		.SYS_DIV    (SYS_DIV)
	) u_clk_div (
		.mclk       (mclk),
		.rstn       (rstn),
		.clkSel     (clkSel_q),
		.secOscSync (secSync_q),
		.lfOscSync  (lfSync_q),
		.srcTick    (srcTick)
	);

	// ************************************************************
	// Prescaler and frame update window
	// ************************************************************
	assign prescWrap  = srcTick & (prescCnt_q == presc_q);
	// Pixel writes are locked while the shadow copy settles
	assign writeAllow = (waBlock_q == 3'h0); // RULE_08

	always @(posedge mclk) begin
		if (!rstn) begin
			prescCnt_q <= 4'h0;
			waBlock_q  <= 3'h0;
			frameTick  <= 1'b0;
		end else begin
			frameTick <= prescWrap;
			if (prescWrap)
				prescCnt_q <= 4'h0;
			else if (srcTick)
				prescCnt_q <= prescCnt_q + 4'h1;
			if (prescWrap)
				waBlock_q <= `LDC_WA_BLOCK;
			else if (waBlock_q != 3'h0)
				waBlock_q <= waBlock_q - 3'h1;
		end
	end

	// ************************************************************
	// Control and prescaler registers
	// ************************************************************
	always @(posedge mclk) begin
		if (!rstn) begin
			biasEn_q <= `LDC_RST_BIASEN;
			clkSel_q <= `LDC_CS_SYSTEM;
			muxSel_q <= `LDC_MUX_STATIC;
			presc_q  <= `LDC_RST_PRESC;
		end else begin
			if (ctrlWrite) begin
				biasEn_q <= pwdata[`LDC_CTRL_BIASEN];
				clkSel_q <= pwdata[`LDC_CTRL_CS_HI:`LDC_CTRL_CS_LO];
				muxSel_q <= pwdata[`LDC_CTRL_MUX_HI:`LDC_CTRL_MUX_LO];
			end
			if (wrAccess && paddr == `LDC_OFS_PRESC)
				presc_q <= pwdata[3:0];
		end
	end

	// ************************************************************
	// Write-failed flag
	// ************************************************************
	assign pixFail = pixWrite & ~writeAllow; // RULE_01

	// Software clears by writing zero; a failure in the same cycle wins
	always @* begin
		write_failed_error_flag_d = write_failed_error_flag_q; // RULE_02
		if (ctrlWrite && !pwdata[`LDC_CTRL_WRITE_FAILED_ERROR_FLAG])
			write_failed_error_flag_d = 1'b0;
		if (pixFail)
			write_failed_error_flag_d = 1'b1; // RULE_01
	end

	always @(posedge mclk) begin
		if (!rstn)
			write_failed_error_flag_q <= 1'b0;
		else
			write_failed_error_flag_q <= write_failed_error_flag_d;
	end

	// ************************************************************
	// Pixel data and display shadow
	// ************************************************************
	// Blocked writes are dropped so the glass never shows a torn frame
	always @(posedge mclk) begin
		if (!rstn) begin
			for (i = 0; i < 4; i = i + 1)
				pixMem_q[i] <= 8'h00;
			pixelData <= 32'h0000_0000;
		end else begin
			if (pixWrite && writeAllow)
				pixMem_q[pixIdx] <= pwdata[7:0];
			if (prescWrap)
				pixelData <= {pixMem_q[3], pixMem_q[2], pixMem_q[1], pixMem_q[0]};
		end
	end

	// ************************************************************
	// Glass drive outputs
	// ************************************************************
	always @(posedge mclk) begin
		if (!rstn) begin
			biasPinEnable <= 1'b0;
			commonEnable  <= 4'h1;
			staticBias    <= 1'b1;
		end else begin
			biasPinEnable <= biasEn_q; // RULE_03
			staticBias    <= (muxSel_q == `LDC_MUX_STATIC); // RULE_07
			case (muxSel_q)
				`LDC_MUX_STATIC: begin
					commonEnable <= 4'h1; // RULE_07
				end
				`LDC_MUX_HALF: begin
					commonEnable <= 4'h3;
				end
				`LDC_MUX_THIRD: begin
					commonEnable <= 4'h7;
				end
				default: begin
					commonEnable <= 4'hF;
				end
			endcase
		end
	end

	// ************************************************************
	// Interrupt status and mask
	// ************************************************************
	always @* begin
		intStat_d = intStat_q;
		if (statWrite)
			intStat_d = intStat_q & ~pwdata[1:0];
		if (pixFail)
			intStat_d[`LDC_INT_WRITE_FAILED_ERROR_FLAG] = 1'b1;
		if (prescWrap)
			intStat_d[`LDC_INT_FRAME] = 1'b1;
	end

	always @(posedge mclk) begin
		if (!rstn) begin
			intStat_q <= 2'h0;
			intMask_q <= `LDC_RST_MASK;
			irq       <= 1'b0;
		end else begin
			intStat_q <= intStat_d;
			if (wrAccess && paddr == `LDC_OFS_INTMASK)
				intMask_q <= pwdata[1:0];
			irq <= |(intStat_d & intMask_q);
		end
	end

	// ************************************************************
	// Read path
	// ************************************************************
	// Captured in the setup cycle so prdata comes from a flop
	always @* begin
		rdWord = 8'h00;
		if (isPixel(paddr)) begin
			rdWord = pixMem_q[pixIdx];
		end else begin
			case (paddr)
				`LDC_OFS_CTRL: begin
					rdWord = {2'h0, write_failed_error_flag_q, biasEn_q, clkSel_q, muxSel_q};
				end
				`LDC_OFS_PRESC: begin
					rdWord = {3'h0, writeAllow, presc_q}; // RULE_08
				end
				`LDC_OFS_INTSTAT: begin
					rdWord = {6'h00, intStat_q};
				end
				`LDC_OFS_INTMASK: begin
					rdWord = {6'h00, intMask_q};
				end
				default: begin
					rdWord = 8'h00;
				end
			endcase
		end
	end

	always @(posedge mclk) begin
		if (!rstn)
			prdata <= 32'h0000_0000;
		else if (setup && !pwrite)
			prdata <= {24'h00_0000, rdWord};
	end

endmodule
`default_nettype wire

// ==== ldc_control_monitor.sv ====
// Purpose: Port checks for the display control block
// Assumes: Zero-wait slave, system divider of at least 9
// Notes:   Bound from the testbench top file
`timescale 1ns/1ps
`default_nettype none
module ldc_control_monitor (
	input wire logic        mclk,
	input wire logic        rstn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        biasPinEnable,
	input wire logic [3:0]  commonEnable,
	input wire logic        staticBias,
	input wire logic [31:0] pixelData,
	input wire logic        frameTick,
	input wire logic        writeAllow
);
	// ****************
	// Checks
	// ****************
	default clocking @(posedge mclk); endclocking
	default disable iff (!rstn);
	wire acc = psel && penable;
	wire mapped = paddr[1:0] == 2'h0 && paddr <= 8'h24 && paddr != 8'h08 && paddr != 8'h0C;
	sequence lockWin;
		(!writeAllow)[*4] ##1 writeAllow;
	endsequence
	sequence quiet;
		(!frameTick)[*8];
	endsequence
	a_ready_high: assert property (pready) else $error("pready low");
	a_map_err: assert property (acc |-> pslverr == !mapped) else $error("bad pslverr");
	a_frame_gap: assert property (frameTick |=> quiet) else $error("frames too close");
	a_lock_win: assert property (frameTick |-> lockWin) else $error("bad lock");
	a_wa_fall: assert property ($fell(writeAllow) |-> frameTick) else $error("stray lock");
	a_static_mux: assert property (staticBias == (commonEnable == 4'h1)) else $error("mux");
	a_bias_write: assert property (acc && pwrite && paddr == 8'h00
		|-> ##2 biasPinEnable == $past(pwdata[4], 2)) else $error("bias bit");
	a_pix_frame: assert property ($changed(pixelData) |-> frameTick) else $error("pix");
	a_rd_upper: assert property (prdata[31:8] == 24'h00_0000) else $error("upper bits");
endmodule
`default_nettype wire

// ==== ldc_glass.sv ====
// Purpose: Stand-in for the display glass on segment and common pins
// Assumes: Image is valid in the cycle of the frame pulse
// Notes:   Keeps its last image while bias pins or common 0 are off
`timescale 1ns/1ps
`default_nettype none
module ldc_glass (
	input  wire logic        mclk,
	input  wire logic        biasOn,
	input  wire logic [3:0]  commons,
	input  wire logic [31:0] image,
	input  wire logic        frame,
	output var  logic [31:0] shown
);
	// ****************
	// Glass image
	// ****************
	initial shown = 32'h0000_0000;
	always @(posedge mclk) begin
		if (frame && biasOn && commons[0])
			shown <= image;
	end
endmodule
`default_nettype wire

// ==== ldc_map.vh ====
// Purpose: Register offsets, fields, reset values and timing counts
// Assumes: APB byte addresses, one aligned 32-bit word per register
// Notes:   Definitions only
`ifndef LDC_MAP_VH
`define LDC_MAP_VH

// ************************************************************
// Register offsets
// ************************************************************
`define LDC_OFS_CTRL      8'h00
`define LDC_OFS_PRESC     8'h04
`define LDC_OFS_PIX0      8'h10
`define LDC_OFS_PIX3      8'h1C
`define LDC_OFS_INTSTAT   8'h20
`define LDC_OFS_INTMASK   8'h24

// ************************************************************
// Field positions
// ************************************************************
`define LDC_CTRL_WRITE_FAILED_ERROR_FLAG     5
`define LDC_CTRL_BIASEN   4
`define LDC_CTRL_CS_HI    3
`define LDC_CTRL_CS_LO    2
`define LDC_CTRL_MUX_HI   1
`define LDC_CTRL_MUX_LO   0
`define LDC_PRESC_WA      4
`define LDC_INT_WRITE_FAILED_ERROR_FLAG      0
`define LDC_INT_FRAME     1

// ************************************************************
// Encodings and reset values
// ************************************************************
`define LDC_CS_SYSTEM     2'h0
`define LDC_CS_SECOND     2'h1
`define LDC_MUX_STATIC    2'h0
`define LDC_MUX_HALF      2'h1
`define LDC_MUX_THIRD     2'h2
`define LDC_RST_CTRL      8'h00
`define LDC_RST_BIASEN    1'b0
`define LDC_RST_PRESC     4'h0
`define LDC_RST_MASK      2'h0

// ************************************************************
// Timing counts
// ************************************************************
`define LDC_SYS_DIV       8192
`define LDC_OSC_DIV       5'h1F
`define LDC_WA_BLOCK      3'h4

`endif

// ==== testbench.sv ====
// Purpose: Register-level tests of the display control block
// Assumes: System divider shortened to 16
// Notes:   Oscillators are made from mclk, periods 4 and 6 cycles
`timescale 1ns/1ps
`default_nettype none
`include "ldc_map.vh"
module testbench;
	localparam int SDIV = 16;
	logic        mclk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
	logic        secOsc = 0, lfOsc = 0, err;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000, prdata, pixelData, shown, rdv;
	logic        pready, pslverr, irq, biasPinEnable, staticBias, frameTick, writeAllow;
	logic [3:0]  commonEnable;
	int          badCount = 0, checkCount = 0, cyc = 0, per;
	int          exp [4] = '{SDIV, 128, 192, 192};
	always #12.5 mclk = ~mclk;
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc % 2 == 1) secOsc <= ~secOsc;
		if (cyc % 3 == 2) lfOsc <= ~lfOsc;
		if (cyc == 20000) begin
			badCount++;
			reportAndStop();
		end
	end
	ldc_control #(.SYS_DIV(SDIV)) dut (.mclk(mclk), .rstn(rstn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
		.secOscPin(secOsc), .lfOscPin(lfOsc), .biasPinEnable(biasPinEnable),
		.commonEnable(commonEnable), .staticBias(staticBias), .pixelData(pixelData),
		.frameTick(frameTick), .writeAllow(writeAllow));
	ldc_glass glass (.mclk(mclk), .biasOn(biasPinEnable), .commons(commonEnable),
		.image(pixelData), .frame(frameTick), .shown(shown));
	// ****************
	// Tasks
	// ****************
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk) penable <= 1;
		do @(posedge mclk); while (pready !== 1'b1);
		rdv = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
		// Registered outputs settle one edge later; look mid-cycle
		@(posedge mclk);
		@(negedge mclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d); xfer(1, a, d); endtask
	task automatic rd(input logic [7:0] a); xfer(0, a, 32'h0000_0000); endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] want);
		checkCount++;
		if (got !== want) begin
			badCount++;
			$display("mismatch at %0t: got %h want %h", $time, got, want);
		end
	endtask
	// Ends just after the rising edge that follows a frame pulse
	task automatic waitFrame();
		do @(negedge mclk); while (frameTick !== 1'b1);
		@(posedge mclk);
	endtask
	task automatic period(output int n);
		waitFrame();
		n = 0;
		do begin
			@(negedge mclk);
			n++;
		end while (frameTick !== 1'b1);
		@(posedge mclk);
	endtask
	task automatic reportAndStop();
		$display("checks %0d mismatches %0d", checkCount, badCount);
		if (badCount == 0 && checkCount > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge mclk);
		rstn <= 1;
		@(posedge mclk);
		rd(`LDC_OFS_CTRL); chk(rdv, 32'h0000_0000);
		rd(`LDC_OFS_PRESC); chk(rdv, 32'h0000_0010);
		chk(32'({staticBias, commonEnable}), 32'h0000_0011);
		wr(`LDC_OFS_CTRL, 32'h0000_0010); chk(32'(biasPinEnable), 32'h0000_0001);
		for (int i = 0; i < 4; i++) begin
			wr(`LDC_OFS_CTRL, 32'h0000_0010 | (i << 2));
			period(per); chk(per, exp[i]);
		end
		wr(`LDC_OFS_CTRL, 32'h0000_0010);
		wr(`LDC_OFS_PRESC, 32'h0000_0011);
		period(per); chk(per, 2 * SDIV);
		wr(`LDC_OFS_PRESC, 32'h0000_0000);
		wr(`LDC_OFS_INTMASK, 32'h0000_0001);
		waitFrame();
		// Wait out the write lock, then fit both writes before the next frame
		repeat (4) @(posedge mclk);
		wr(`LDC_OFS_PIX0, 32'h0000_00A5);
		wr(`LDC_OFS_PIX3, 32'h0000_003C);
		rd(`LDC_OFS_CTRL); chk(rdv, 32'h0000_0010);
		waitFrame(); chk(pixelData, 32'h3C00_00A5);
		wr(`LDC_OFS_PIX0, 32'h0000_00FF);
		rd(`LDC_OFS_CTRL); chk(rdv, 32'h0000_0030);
		chk(32'(irq), 32'h0000_0001);
		chk(shown, 32'h3C00_00A5);
		wr(`LDC_OFS_INTSTAT, 32'h0000_0001); chk(32'(irq), 32'h0000_0000);
		repeat (40) @(posedge mclk);
		rd(`LDC_OFS_CTRL); chk(rdv, 32'h0000_0030);
		chk(pixelData, 32'h3C00_00A5);
		wr(`LDC_OFS_CTRL, 32'h0000_0010);
		rd(`LDC_OFS_CTRL); chk(rdv, 32'h0000_0010);
		waitFrame();
		rd(`LDC_OFS_PRESC); chk(rdv, 32'h0000_0000);
		rd(8'h30); chk(32'(err), 32'h0000_0001);
		chk(rdv, 32'h0000_0000);
		wr(`LDC_OFS_CTRL, 32'h0000_0000); chk(32'(biasPinEnable), 32'h0000_0000);
		reportAndStop();
	end
endmodule
bind ldc_control ldc_control_monitor mon (.mclk(mclk), .rstn(rstn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr),
	.biasPinEnable(biasPinEnable), .commonEnable(commonEnable),
	.staticBias(staticBias), .pixelData(pixelData), .frameTick(frameTick),
	.writeAllow(writeAllow));
`default_nettype wire
